// File: dv/dbcpm_drop_rx.sv
// Drop-side receiver model that logs every qualified drop bus byte
`timescale 1ns/1ps
`default_nettype none
module dbcpm_drop_rx
    import dbcpm_pkg::*;
(
    input wire logic clk,
    input wire logic en,
    input wire logic [dbcpm_pkg::BYTE_W-1:0] data,
    input wire logic payload,
    input wire logic marker
);
    import dbcpm_pkg::*;
    // Entry {marker, payload, byte}: with marker, low flag is C1, high is J1
    logic [BYTE_W+1:0] log_q[$];
    always @(posedge clk) begin
        if (en && (marker || !payload || data != IDLE_BYTE)) begin
            log_q.push_back({marker, payload, data});
        end
    end
endmodule // dbcpm_drop_rx
`default_nettype wire

// File: dv/tb_drop_bus_c1_j1_phase_marker.sv
// Self-checking bench for the drop bus phase marker block
`timescale 1ns/1ps
`default_nettype none
module tb_drop_bus_c1_j1_phase_marker;
    import dbcpm_pkg::*;
    // Words {j1, c1, toh, byte} and the drop bus entries they must give
    localparam logic [10:0] WORDS [4] = '{11'h3A1, 11'h45B, 11'h177, 11'h03C};
    localparam logic [9:0] EXPS [4] = '{10'h2A1, 10'h35B, 10'h077, 10'h13C};
    logic mclk = 1'b0, rst = 1'b0, ck1 = 1'b0, ck2 = 1'b0;
    logic [NCH-1:0] en = '1, vld = '0, rdy, toh = '0, c1 = '0, j1 = '0;
    logic [NCH-1:0][BYTE_W-1:0] byt = '0;
    logic [BYTE_W-1:0] d1, d2;
    logic p1, p2, m1, m2;
    int n_mismatch = 0;
    int n_compared = 0;
    initial forever #10 mclk = ~mclk;
    initial forever #40 ck1 = ~ck1;
    initial begin
        #27;
        forever #40 ck2 = ~ck2;
    end
    dbcpm_top dut_u (.MCLK(mclk), .RST(rst), .TBUS_ENABLE(en), .SRC_VALID(vld),
        .SRC_READY(rdy), .SRC_BYTE(byt), .SRC_TOH(toh), .SRC_C1(c1), .SRC_J1(j1),
        .DROP_BUS_CLOCK_CH1(ck1), .DROP_BUS_CLOCK_CH2(ck2),
        .DROP_DATA_BYTE_CH1(d1), .DROP_DATA_BYTE_CH2(d2),
        .DROP_PAYLOAD_FLAG_CH1(p1), .DROP_PAYLOAD_FLAG_CH2(p2),
        .DROP_PHASE_MARKER_CH1(m1), .DROP_PHASE_MARKER_CH2(m2));
    dbcpm_drop_rx rx1_u (.clk(ck1), .en(en[0]), .data(d1), .payload(p1), .marker(m1));
    dbcpm_drop_rx rx2_u (.clk(ck2), .en(en[1]), .data(d2), .payload(p2), .marker(m2));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic dclk(input int ch, input int n);
        repeat (n) begin
            if (ch == 0) @(posedge ck1);
            else @(posedge ck2);
        end
    endtask
    function automatic int logsz(input int ch);
        return (ch == 0) ? rx1_u.log_q.size() : rx2_u.log_q.size();
    endfunction
    function automatic logic [9:0] entry(input int ch, input int i);
        return (ch == 0) ? rx1_u.log_q[i] : rx2_u.log_q[i];
    endfunction
    // Holds the word until the buffer takes it
    task automatic push(input int ch, input logic [10:0] w);
        int n;
        n = 0;
        vld[ch] <= 1'b1;
        byt[ch] <= w[7:0];
        toh[ch] <= w[F_TOH];
        c1[ch] <= w[F_C1];
        j1[ch] <= w[F_J1];
        do begin
            @(posedge mclk);
            n++;
        end while (rdy[ch] !== 1'b1 && n < 200);
        if (rdy[ch] !== 1'b1) begin
            $display("CHECK FAILED at %0t: source never taken", $time);
            n_mismatch++;
            give_verdict();
        end
    endtask
    // Back-to-back C1, J1, overhead and payload words, filling the buffer
    task automatic t_frame(input int ch);
        int n;
        dclk(ch, 6);
        if (ch == 0) rx1_u.log_q.delete();
        else rx2_u.log_q.delete();
        @(posedge mclk);
        foreach (WORDS[i]) push(ch, WORDS[i]);
        vld[ch] <= 1'b0;
        n = 0;
        while (logsz(ch) < 4 && n < 40) begin
            dclk(ch, 1);
            n++;
        end
        dclk(ch, 3);
        check(16'(logsz(ch)), 16'h0004, "wrong count of marked or data bytes");
        for (int i = 0; i < 4; i++) begin
            check(16'(entry(ch, i)), 16'(EXPS[i]), "marker, flag or byte wrong");
        end
    endtask
    // Disabled channel carries the line clock on the marker pin
    task automatic t_off(input int ch);
        logic prev;
        en[ch] <= 1'b0;
        dclk(ch, 6);
        prev = ch ? m2 : m1;
        for (int i = 0; i < 6; i++) begin
            dclk(ch, 1);
            check(16'(ch ? m2 : m1), 16'(!prev), "line clock not toggling");
            check(16'(ch ? {p2, d2} : {p1, d1}), 16'({IDLE_PAYLOAD, IDLE_BYTE}), "idle wrong");
            prev = ch ? m2 : m1;
        end
        en[ch] <= 1'b1;
    endtask
    initial begin
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (20) @(posedge mclk);
        for (int ch = 0; ch < NCH; ch++) begin
            t_frame(ch);
            $display("test frame on channel %0d done", ch + 1);
        end
        t_off(1);
        $display("test disabled channel done");
        t_frame(1);
        $display("test re-enabled channel done");
        give_verdict();
    end
endmodule // tb_drop_bus_c1_j1_phase_marker
`default_nettype wire

// File: rtl/dbcpm_afifo.sv
// Dual-clock buffer with gray-coded pointers and valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dbcpm_afifo #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic wclk,
    input wire logic wrst,
    input wire logic w_valid,
    output logic w_ready,
    input wire logic [W-1:0] w_data,
    input wire logic rclk,
    input wire logic rrst,
    output logic r_valid,
    input wire logic r_ready,
    output logic [W-1:0] r_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_MASK = (AW + 1)'(3) << (AW - 1);

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wbin_q, wgray_q, wbin_d;
    logic [AW:0] rbin_q, rgray_q, rbin_d;
    logic [AW:0] rg_m_q, rg_s_q, wg_m_q, wg_s_q;
    logic w_ready_q, r_valid_q, push, pop;

    assign push = w_valid && w_ready_q;
    assign pop = r_valid_q && r_ready;
    assign wbin_d = wbin_q + (AW + 1)'(push);
    assign rbin_d = rbin_q + (AW + 1)'(pop);
    assign w_ready = w_ready_q;
    assign r_valid = r_valid_q;
    assign r_data = mem[rbin_q[AW-1:0]];

    always_ff @(posedge wclk) begin
        if (push) begin
            mem[wbin_q[AW-1:0]] <= w_data;
        end
    end

    // Write side: full is registered after a two-flop read pointer sync, so it lags a freed slot by three write clocks
    always_ff @(posedge wclk or posedge wrst) begin
        if (wrst) begin
            wbin_q <= '0;
            wgray_q <= '0;
            rg_m_q <= '0;
            rg_s_q <= '0;
            w_ready_q <= 1'b0;
        end else begin
            wbin_q <= wbin_d;
            wgray_q <= bin2gray(wbin_d);
            rg_m_q <= rgray_q;
            rg_s_q <= rg_m_q;
            w_ready_q <= (bin2gray(wbin_d) ^ rg_s_q) != FULL_MASK;
        end
    end

    always_ff @(posedge rclk or posedge rrst) begin
        if (rrst) begin
            rbin_q <= '0;
            rgray_q <= '0;
            wg_m_q <= '0;
            wg_s_q <= '0;
            r_valid_q <= 1'b0;
        end else begin
            rbin_q <= rbin_d;
            rgray_q <= bin2gray(rbin_d);
            wg_m_q <= wgray_q;
            wg_s_q <= wg_m_q;
            r_valid_q <= bin2gray(rbin_d) != wg_s_q;
        end
    end
endmodule // dbcpm_afifo
`default_nettype wire

// File: rtl/dbcpm_pkg.sv
// Shared constants for the drop bus C1/J1 phase marker block
package dbcpm_pkg;
    localparam int NCH = 2;
    localparam int BYTE_W = 8;
    localparam int BUF_DEPTH = 2;
    // Buffered word layout: {j1, c1, toh, byte}
    localparam int F_BYTE_LSB = 0;
    localparam int F_TOH = 8;
    localparam int F_C1 = 9;
    localparam int F_J1 = 10;
    localparam int WORD_W = 11;
    // Values driven while nothing is queued or the bus is disabled, then reset values
    localparam logic [BYTE_W-1:0] IDLE_BYTE = 8'h00;
    localparam logic IDLE_PAYLOAD = 1'b1;
    localparam logic MARKER_RST = 1'b0;
    localparam logic PAYLOAD_RST = 1'b1;
    localparam logic [1:0] SYNC_RST = 2'h3;
endpackage

// File: rtl/dbcpm_top.sv
// Drop bus byte, payload flag and C1/J1 phase marker for two channels
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Shared pin is phase marker when bus enabled, line clock otherwise.
// - With bus disabled the shared pin carries the transmit line clock.
// - Enabled: marker high only for C1 or J1 bytes, else low.
// - C1 byte: marker high one drop clock, payload flag low.
// - J1 byte: marker high one drop clock, payload flag high.
// - Payload flag low for overhead bytes, high for all others.
module dbcpm_top
    import dbcpm_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [dbcpm_pkg::NCH-1:0] TBUS_ENABLE,
    input wire logic [dbcpm_pkg::NCH-1:0] SRC_VALID,
    output logic [dbcpm_pkg::NCH-1:0] SRC_READY,
    input wire logic [dbcpm_pkg::NCH-1:0][dbcpm_pkg::BYTE_W-1:0] SRC_BYTE,
    input wire logic [dbcpm_pkg::NCH-1:0] SRC_TOH,
    input wire logic [dbcpm_pkg::NCH-1:0] SRC_C1,
    input wire logic [dbcpm_pkg::NCH-1:0] SRC_J1,
    input wire logic DROP_BUS_CLOCK_CH1,
    input wire logic DROP_BUS_CLOCK_CH2,
    output logic [dbcpm_pkg::BYTE_W-1:0] DROP_DATA_BYTE_CH1,
    output logic [dbcpm_pkg::BYTE_W-1:0] DROP_DATA_BYTE_CH2,
    output logic DROP_PAYLOAD_FLAG_CH1,
    output logic DROP_PAYLOAD_FLAG_CH2,
    output logic DROP_PHASE_MARKER_CH1,
    output logic DROP_PHASE_MARKER_CH2
);
    import dbcpm_pkg::*;

    // Payload flag for one byte; C1 is overhead, J1 is payload
    function automatic logic payload_of(input logic [WORD_W-1:0] w);
        if (w[F_C1]) begin
            return 1'b0;
        end else if (w[F_J1]) begin
            return 1'b1;
        end
        return !w[F_TOH];
    endfunction

    function automatic logic marks(input logic [WORD_W-1:0] w);
        return w[F_C1] || w[F_J1];
    endfunction

    logic [NCH-1:0] lclk;
    logic [NCH-1:0] marker_w, payload_w;
    logic [NCH-1:0][BYTE_W-1:0] data_w;

    assign lclk = {DROP_BUS_CLOCK_CH2, DROP_BUS_CLOCK_CH1};
    assign DROP_DATA_BYTE_CH1 = data_w[0];
    assign DROP_DATA_BYTE_CH2 = data_w[1];
    assign DROP_PAYLOAD_FLAG_CH1 = payload_w[0];
    assign DROP_PAYLOAD_FLAG_CH2 = payload_w[1];
    assign DROP_PHASE_MARKER_CH1 = marker_w[0];
    assign DROP_PHASE_MARKER_CH2 = marker_w[1];

    logic mrst_m_q, mrst_q;

    // Reset release retimed onto the system clock
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            {mrst_m_q, mrst_q} <= SYNC_RST;
        end else begin
            mrst_m_q <= 1'b0;
            mrst_q <= mrst_m_q;
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic lrst_m_q, lrst_q;
        logic en_m_q, en_s_q;
        logic r_valid;
        logic [WORD_W-1:0] w_word, r_word;
        logic marker_q, payload_q;
        logic [BYTE_W-1:0] data_q;

        assign w_word = {SRC_J1[c], SRC_C1[c], SRC_TOH[c], SRC_BYTE[c]};

        // Reset release retimed onto the drop clock
        always_ff @(posedge lclk[c] or posedge RST) begin
            if (RST) begin
                {lrst_m_q, lrst_q} <= SYNC_RST;
            end else begin
                lrst_m_q <= 1'b0;
                lrst_q <= lrst_m_q;
            end
        end

        // Bus enable level brought into the drop clock domain
        always_ff @(posedge lclk[c] or posedge lrst_q) begin
            if (lrst_q) begin
                en_m_q <= 1'b0;
                en_s_q <= 1'b0;
            end else begin
                en_m_q <= TBUS_ENABLE[c];
                en_s_q <= en_m_q;
            end
        end

        // Words are drained every drop clock; discarded while disabled
        dbcpm_afifo #(
            .W(WORD_W),
            .DEPTH(BUF_DEPTH)
        ) u_buf (
            .wclk(MCLK),
            .wrst(mrst_q),
            .w_valid(SRC_VALID[c]),
            .w_ready(SRC_READY[c]),
            .w_data(w_word),
            .rclk(lclk[c]),
            .rrst(lrst_q),
            .r_valid(r_valid),
            .r_ready(1'b1),
            .r_data(r_word)
        );

        // Data byte and its qualifiers leave on one edge
        always_ff @(posedge lclk[c] or posedge lrst_q) begin
            if (lrst_q) begin
                data_q <= IDLE_BYTE;
                payload_q <= PAYLOAD_RST;
            end else if (en_s_q && r_valid) begin
                data_q <= r_word[F_BYTE_LSB +: BYTE_W];
                payload_q <= payload_of(r_word);
            end else begin
                data_q <= IDLE_BYTE;
                payload_q <= IDLE_PAYLOAD;
            end
        end

        // Shared pin: marker when enabled, half-rate line clock otherwise
        always_ff @(posedge lclk[c] or posedge lrst_q) begin
            if (lrst_q) begin
                marker_q <= MARKER_RST;
            end else if (!en_s_q) begin
                marker_q <= !marker_q;
            end else begin
                marker_q <= r_valid && marks(r_word);
            end
        end

        assign data_w[c] = data_q;
        assign payload_w[c] = payload_q;
        assign marker_w[c] = marker_q;

        property p_line_clock;
            @(posedge lclk[c]) disable iff (lrst_q)
            !$past(lrst_q) && !$past(en_s_q) |-> marker_q != $past(marker_q);
        endproperty
        a_line_clock: assert property (p_line_clock)
            else $error("line clock did not toggle while bus disabled");

        property p_marker_quiet;
            @(posedge lclk[c]) disable iff (lrst_q)
            $past(en_s_q) && !($past(r_valid) && $past(marks(r_word))) |-> !marker_q;
        endproperty
        a_marker_quiet: assert property (p_marker_quiet)
            else $error("marker high without C1 or J1 byte");

        property p_function_select;
            @(posedge lclk[c]) disable iff (lrst_q)
            en_s_q && $past(en_s_q) && !r_valid ##1 en_s_q |-> !marker_q;
        endproperty
        a_function_select: assert property (p_function_select)
            else $error("shared pin not acting as marker while enabled");

        sequence s_c1_out;
            en_s_q && r_valid && r_word[F_C1];
        endsequence
        property p_c1;
            @(posedge lclk[c]) disable iff (lrst_q)
            s_c1_out |=> marker_q && !payload_q && data_q == $past(r_word[F_BYTE_LSB +: BYTE_W]);
        endproperty
        a_c1: assert property (p_c1)
            else $error("C1 byte not marked with payload flag low");

        property p_j1;
            @(posedge lclk[c]) disable iff (lrst_q)
            en_s_q && r_valid && r_word[F_J1] && !r_word[F_C1] |=> marker_q && payload_q;
        endproperty
        a_j1: assert property (p_j1)
            else $error("J1 byte not marked with payload flag high");

        property p_one_period;
            @(posedge lclk[c]) disable iff (lrst_q)
            $past(en_s_q) && en_s_q && !r_valid |=> !marker_q;
        endproperty
        a_one_period: assert property (p_one_period)
            else $error("marker lasted longer than one drop clock");

        property p_overhead;
            @(posedge lclk[c]) disable iff (lrst_q)
            en_s_q && r_valid && !r_word[F_J1] |=> payload_q == !$past(r_word[F_TOH] || r_word[F_C1]);
        endproperty
        a_overhead: assert property (p_overhead)
            else $error("payload flag wrong for overhead or payload byte");

        property p_same_edge;
            @(posedge lclk[c]) disable iff (lrst_q)
            en_s_q && r_valid ##1 marker_q |-> data_q == $past(r_word[F_BYTE_LSB +: BYTE_W])
                && payload_q == $past(!r_word[F_C1] && (r_word[F_J1] || !r_word[F_TOH]));
        endproperty
        a_same_edge: assert property (p_same_edge)
            else $error("marker not aligned with its data byte");

        property p_idle_bus;
            @(posedge lclk[c]) disable iff (lrst_q)
            !(en_s_q && r_valid) |=> data_q == IDLE_BYTE && payload_q == IDLE_PAYLOAD;
        endproperty
        a_idle_bus: assert property (p_idle_bus)
            else $error("drop bus not idle without a queued byte");

        property p_plain_byte;
            @(posedge lclk[c]) disable iff (lrst_q)
            en_s_q && r_valid && !r_word[F_C1] && !r_word[F_J1] |=> !marker_q;
        endproperty
        a_plain_byte: assert property (p_plain_byte)
            else $error("marker high for a byte that is neither C1 nor J1");

        property p_byte_edge;
            @(posedge lclk[c]) disable iff (lrst_q)
            en_s_q && r_valid |=> data_q == $past(r_word[F_BYTE_LSB +: BYTE_W]);
        endproperty
        a_byte_edge: assert property (p_byte_edge)
            else $error("data byte did not leave with its qualifiers");

        c_c1: cover property (@(posedge lclk[c]) disable iff (lrst_q) marker_q && !payload_q);
        c_j1: cover property (@(posedge lclk[c]) disable iff (lrst_q) marker_q && payload_q && en_s_q);
        c_full: cover property (@(posedge MCLK) disable iff (RST) SRC_VALID[c] && !SRC_READY[c]);
        c_disable: cover property (@(posedge lclk[c]) disable iff (lrst_q) $fell(en_s_q));
        c_line_clock: cover property (@(posedge lclk[c]) disable iff (lrst_q) !en_s_q && marker_q);
    end
endmodule // dbcpm_top
`default_nettype wire
